// ==== config_word_decode_and_protect.sv ====
// Purpose: hold and decode configuration words, gate external and
//   self-write access, report stack faults
// Assumes: one 40 MHz clock, synchronous active-high reset
// Notes: decoded words change only at reset or on a reload command; software enable bits follow live
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps

// Notes on behaviour
// - first configuration word at 8007h, second at 8008h, fourteen bits each.
// - unimplemented bits read one; blank or erased bits are all one.
// - first word bit 13 set enables the fail-safe clock monitor.
// - first word bit 12 set enables internal/external clock switchover.
// - crystal modes ignore clock output bit; else cleared drives clock out.
// - brown-out field: 11 on, 10 run only, 01 software bit, 00 off.
// - cleared code protect blocks external access; external reads return zero.
// - reset pin bit ignored under low-voltage programming; else reset or input.
// - cleared power-up bit enables the power-up delay.
// - watchdog field: 11 on, 10 run only, 01 software bit, 00 off.
// - oscillator field selects external clock, internal, RC or crystal.
// - low-voltage bit allows low-voltage entry; else high voltage needed.
// - cleared debugger bit dedicates programming pins to the debugger.
// - cleared low-power brown-out bit enables the low-power detector.
// - brown-out trip select set picks low trip point, cleared high.
// - stack reset bit set makes stack overflow or underflow reset.
// - regulator capacitor enabled by cleared bit, only on regulator variant.
// - small part self-write protect: none, to 1FFh, to 3FFh, to 7FFh.
// - large part self-write protect: none, to 1FFh, to 7FFh, to FFFh.
// - four user identification words at 8000h-8003h, readable and writable.
// - identity word at 8006h: part code bits 13-5, step bits 4-0.
// - stack fault sets overflow or underflow flag; reset when enabled.
module config_word_decode_and_protect #(
	parameter bit LARGE_FLASH = 1'b0,
	parameter bit REGULATOR_PRESENT = 1'b1,
	// arbitrary identity values
	parameter logic [8:0] PART_CODE = 9'h0A5,
	parameter logic [4:0] STEP_CODE = 5'h01
) (
	input logic clk,
	input logic srst,
	input config_pkg::axi_req_type axi_req,
	output config_pkg::axi_rsp_type axi_rsp,
	input logic software_brownout_enable,
	input logic software_watchdog_enable,
	input logic reset_pin_pullup_bit,
	input logic stack_overflow_event,
	input logic stack_underflow_event,
	output logic stack_fault_reset,
	input logic ext_read_valid,
	input logic [13:0] ext_read_data_raw,
	output logic [13:0] ext_read_data,
	input logic ext_write_request,
	output logic ext_write_allowed,
	input logic self_write_request,
	input logic [14:0] self_write_address,
	output logic self_write_allowed,
	input logic external_reset_pin_high_voltage,
	input logic low_voltage_entry_pin,
	output logic programming_entry_allowed,
	output config_pkg::settings_type settings
);
	import config_pkg::*;

	typedef struct packed {
		logic aw_have;
		logic [17:0] aw_idx;
		logic w_have;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [13:0] nv_word1;
		logic [13:0] nv_word2;
		logic [3:0][13:0] user_id;
		logic [13:0] active_word1;
		logic [13:0] active_word2;
		logic overflow_flag;
		logic underflow_flag;
		logic stack_fault_reset;
		logic [13:0] ext_read_data;
		logic hv_meta;
		logic hv_sync;
		logic lv_meta;
		logic lv_sync;
		logic programming_entry_allowed;
		settings_type settings;
	} state_type;

	state_type s_q;
	state_type s_d;
	logic wp_on;
	logic [14:0] wp_end;

	function automatic logic [13:0] merge14(input logic [13:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [13:0] r;
		r = old;
		if (strb[0])
		begin
			r[7:0] = data[7:0];
		end
		if (strb[1])
		begin
			r[13:8] = data[13:8];
		end
		return r;
	endfunction : merge14

	// two-bit enable field to run and sleep enables
	function automatic logic [1:0] mode_decode(input logic [1:0] field,
		input logic sw_bit);
		logic [1:0] r;
		r = 2'b00;
		unique case (enable_mode_type'(field))
			mode_always_on: r = 2'b11;
			mode_run_only: r = 2'b10;
			mode_software: r = {sw_bit, sw_bit};
			mode_off: r = 2'b00;
		endcase
		return r;
	endfunction : mode_decode

	function automatic settings_type decode(input logic [13:0] w1,
		input logic [13:0] w2, input logic sw_bor, input logic sw_wdt,
		input logic pullup_bit);
		settings_type r;
		logic [1:0] bor;
		logic [1:0] wdt;
		r = '0;
		bor = mode_decode(w1[BROWNOUT_LSB +: 2], sw_bor);
		wdt = mode_decode(w1[WATCHDOG_LSB +: 2], sw_wdt);
		r.clock_monitor_enable = w1[CLK_MONITOR_BIT];
		r.two_speed_switchover_enable = w1[SWITCHOVER_BIT];
		r.osc_mode = osc_mode_type'(w1[OSC_LSB +: 3]);
		r.crystal_mode = (r.osc_mode == high_gain_crystal_mode) ||
			(r.osc_mode == medium_gain_crystal_mode) ||
			(r.osc_mode == low_power_crystal_mode);
		// crystal modes keep the pin for the oscillator
		r.clock_output_drive = !r.crystal_mode &&
			!w1[CLOCK_OUTPUT_PIN_SEL_N_BIT];
		r.clock_output_pin_gpio = !r.crystal_mode &&
			w1[CLOCK_OUTPUT_PIN_SEL_N_BIT];
		r.brownout_run_enable = bor[1];
		r.brownout_sleep_enable = bor[0];
		r.watchdog_run_enable = wdt[1];
		r.watchdog_sleep_enable = wdt[0];
		r.code_protect_active = !w1[CODE_PROTECT_N_BIT];
		r.low_voltage_programming_enable = w2[LVP_BIT];
		if (w2[LVP_BIT])
		begin
			// select bit ignored, pin stays an external reset
			r.reset_pin_external = 1'b1;
			r.reset_pin_pullup_enable = 1'b1;
		end
		else
		begin
			r.reset_pin_external = w1[RESET_PIN_SEL_BIT];
			r.reset_pin_pullup_enable = w1[RESET_PIN_SEL_BIT] ||
				pullup_bit;
		end
		r.powerup_delay_enable = !w1[POWERUP_SEL_N_BIT];
		r.debugger_pins_dedicated = !w2[DEBUG_N_BIT];
		r.low_power_brownout_enable = !w2[LP_BROWNOUT_N_BIT];
		r.brownout_trip_low = w2[BROWNOUT_TRIP_BIT];
		r.stack_fault_reset_enable = w2[STACK_RESET_BIT];
		r.regulator_capacitor_enable = REGULATOR_PRESENT &&
			!w2[REG_CAP_N_BIT];
		return r;
	endfunction : decode

	// self-write protected range from the active second word
	always_comb
	begin
		wp_on = 1'b1;
		wp_end = WP_END_512;
		unique case (s_q.active_word2[WRITE_PROTECT_LSB +: 2])
			2'b11: wp_on = 1'b0;
			2'b10: wp_end = WP_END_512;
			2'b01: wp_end = LARGE_FLASH ? WP_END_2K : WP_END_1K;
			2'b00: wp_end = LARGE_FLASH ? WP_END_4K : WP_END_2K;
		endcase
	end

	always_comb
	begin
		logic [17:0] ridx;
		logic [13:0] rword;
		logic rok;
		logic clr_ovf;
		logic clr_unf;
		ridx = axi_req.araddr[19:2];
		rword = '0;
		rok = 1'b1;
		clr_ovf = 1'b0;
		clr_unf = 1'b0;
		s_d = s_q;
		s_d.stack_fault_reset = 1'b0;

		// programmer pins are asynchronous: two flops before any use
		s_d.hv_meta = external_reset_pin_high_voltage;
		s_d.hv_sync = s_q.hv_meta;
		s_d.lv_meta = low_voltage_entry_pin;
		s_d.lv_sync = s_q.lv_meta;
		s_d.programming_entry_allowed = s_q.hv_sync ||
			(s_q.settings.low_voltage_programming_enable &&
			s_q.lv_sync);

		// write address and data are taken in either order
		if (axi_req.awvalid && !s_q.aw_have)
		begin
			s_d.aw_have = 1'b1;
			s_d.aw_idx = axi_req.awaddr[19:2];
		end
		if (axi_req.wvalid && !s_q.w_have)
		begin
			s_d.w_have = 1'b1;
			s_d.wdata = axi_req.wdata;
			s_d.wstrb = axi_req.wstrb;
		end
		if (s_q.bvalid && axi_req.bready)
		begin
			s_d.bvalid = 1'b0;
		end
		// a held pair executes only once the previous response is gone
		if (s_q.aw_have && s_q.w_have && !s_q.bvalid)
		begin
			s_d.aw_have = 1'b0;
			s_d.w_have = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = RESP_OKAY;
			if (s_q.aw_idx >= IDX_USER_ID0 && s_q.aw_idx <= IDX_USER_ID3)
			begin
				s_d.user_id[s_q.aw_idx[1:0]] = merge14(
					s_q.user_id[s_q.aw_idx[1:0]], s_q.wdata,
					s_q.wstrb);
			end
			else
			begin
				case (s_q.aw_idx)
					// live words and identity ignore writes
					IDX_PART_IDENTITY, IDX_CFG_WORD1, IDX_CFG_WORD2,
					IDX_SETTINGS: s_d.bresp = RESP_OKAY;
					IDX_NV_WORD1: s_d.nv_word1 = merge14(s_q.nv_word1,
						s_q.wdata, s_q.wstrb) | CFG1_UNUSED_ONES;
					IDX_NV_WORD2: s_d.nv_word2 = merge14(s_q.nv_word2,
						s_q.wdata, s_q.wstrb) | CFG2_UNUSED_ONES;
					IDX_CONTROL:
					begin
						if (s_q.wstrb[0] && s_q.wdata[CTRL_ERASE_BIT])
						begin
							s_d.nv_word1 = WORD_BLANK;
							s_d.nv_word2 = WORD_BLANK;
							for (int i = 0; i < 4; i++)
							begin
								s_d.user_id[i] = WORD_BLANK;
							end
						end
						// reload acts as the reset-time load
						if (s_q.wstrb[0] && s_q.wdata[CTRL_RELOAD_BIT])
						begin
							s_d.active_word1 = s_d.nv_word1;
							s_d.active_word2 = s_d.nv_word2;
						end
					end
					IDX_POWER_CONTROL:
					begin
						clr_ovf = s_q.wstrb[0] &&
							s_q.wdata[POWER_CONTROL_REGISTER_OVERFLOW_BIT];
						clr_unf = s_q.wstrb[0] &&
							s_q.wdata[POWER_CONTROL_REGISTER_UNDERFLOW_BIT];
					end
					default: s_d.bresp = RESP_SLVERR;
				endcase
			end
		end

		// read channel
		if (ridx >= IDX_USER_ID0 && ridx <= IDX_USER_ID3)
		begin
			rword = s_q.user_id[ridx[1:0]];
		end
		else
		begin
			case (ridx)
				IDX_PART_IDENTITY: rword = {PART_CODE, STEP_CODE};
				IDX_CFG_WORD1: rword = s_q.active_word1 |
					CFG1_UNUSED_ONES;
				IDX_CFG_WORD2: rword = s_q.active_word2 |
					CFG2_UNUSED_ONES;
				IDX_NV_WORD1: rword = s_q.nv_word1;
				IDX_NV_WORD2: rword = s_q.nv_word2;
				IDX_CONTROL: rword = '0;
				IDX_POWER_CONTROL: rword = {12'h000, s_q.underflow_flag,
					s_q.overflow_flag};
				IDX_SETTINGS: rword = '0;
				default: rok = 1'b0;
			endcase
		end
		if (s_q.rvalid && axi_req.rready)
		begin
			s_d.rvalid = 1'b0;
		end
		// a new read waits until the pending answer is taken
		if (axi_req.arvalid && !s_q.rvalid)
		begin
			s_d.rvalid = 1'b1;
			s_d.rresp = rok ? RESP_OKAY : RESP_SLVERR;
			s_d.rdata = {18'h0_0000, rword};
			if (ridx == IDX_SETTINGS)
			begin
				s_d.rdata = 32'(s_q.settings);
			end
		end

		// stack faults: event beats a clear in the same cycle
		s_d.overflow_flag = (s_q.overflow_flag && !clr_ovf) ||
			stack_overflow_event;
		s_d.underflow_flag = (s_q.underflow_flag && !clr_unf) ||
			stack_underflow_event;
		s_d.stack_fault_reset = s_q.settings.stack_fault_reset_enable &&
			(stack_overflow_event || stack_underflow_event);

		// external reads see zeros while protected
		if (ext_read_valid)
		begin
			s_d.ext_read_data = s_q.settings.code_protect_active ?
				14'h0000 : ext_read_data_raw;
		end

		// software enable bits follow live; the words change only at reset or on reload
		s_d.settings = decode(s_q.active_word1, s_q.active_word2,
			software_brownout_enable, software_watchdog_enable,
			reset_pin_pullup_bit);
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			s_q <= '0;
			// blank image, as after a bulk erase
			s_q.nv_word1 <= WORD_BLANK;
			s_q.nv_word2 <= WORD_BLANK;
			s_q.user_id <= {4{WORD_BLANK}};
			s_q.active_word1 <= WORD_BLANK;
			s_q.active_word2 <= WORD_BLANK;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign axi_rsp.awready = !s_q.aw_have;
	assign axi_rsp.wready = !s_q.w_have;
	assign axi_rsp.bvalid = s_q.bvalid;
	assign axi_rsp.bresp = s_q.bresp;
	assign axi_rsp.arready = !s_q.rvalid;
	assign axi_rsp.rvalid = s_q.rvalid;
	assign axi_rsp.rdata = s_q.rdata;
	assign axi_rsp.rresp = s_q.rresp;

	assign stack_fault_reset = s_q.stack_fault_reset;
	assign ext_read_data = s_q.ext_read_data;
	// write gates answer in the same cycle as the request; programming entry is registered
	assign ext_write_allowed = ext_write_request &&
		!s_q.settings.code_protect_active;
	assign self_write_allowed = self_write_request &&
		!(wp_on && self_write_address <= wp_end);
	assign programming_entry_allowed = s_q.programming_entry_allowed;
	assign settings = s_q.settings;

endmodule : config_word_decode_and_protect

// ==== config_pkg.sv ====
// Purpose: shared constants and carriers for configuration decode
// Assumes: 32-bit AXI4-Lite register bus, 20-bit byte addresses
// Notes: register index times four gives the byte address
package config_pkg;

	localparam int ADDR_W = 20;
	localparam int DATA_W = 32;
	localparam int WORD_W = 14;
	localparam int IDX_W = 18;

	// register indices; byte address is four times the index
	localparam logic [17:0] IDX_USER_ID0 = 18'h0_8000;
	localparam logic [17:0] IDX_USER_ID3 = 18'h0_8003;
	localparam logic [17:0] IDX_PART_IDENTITY = 18'h0_8006;
	localparam logic [17:0] IDX_CFG_WORD1 = 18'h0_8007;
	localparam logic [17:0] IDX_CFG_WORD2 = 18'h0_8008;
	localparam logic [17:0] IDX_NV_WORD1 = 18'h0_8010;
	localparam logic [17:0] IDX_NV_WORD2 = 18'h0_8011;
	localparam logic [17:0] IDX_CONTROL = 18'h0_8012;
	localparam logic [17:0] IDX_POWER_CONTROL = 18'h0_8013;
	localparam logic [17:0] IDX_SETTINGS = 18'h0_8014;

	localparam logic [13:0] WORD_BLANK = 14'h3FFF;
	localparam logic [13:0] CFG1_UNUSED_ONES = 14'h0100;
	localparam logic [13:0] CFG2_UNUSED_ONES = 14'h01EC;

	// first word fields
	localparam int CLK_MONITOR_BIT = 13;
	localparam int SWITCHOVER_BIT = 12;
	localparam int CLOCK_OUTPUT_PIN_SEL_N_BIT = 11;
	localparam int BROWNOUT_LSB = 9;
	localparam int CODE_PROTECT_N_BIT = 7;
	localparam int RESET_PIN_SEL_BIT = 6;
	localparam int POWERUP_SEL_N_BIT = 5;
	localparam int WATCHDOG_LSB = 3;
	localparam int OSC_LSB = 0;
	// second word fields
	localparam int LVP_BIT = 13;
	localparam int DEBUG_N_BIT = 12;
	localparam int LP_BROWNOUT_N_BIT = 11;
	localparam int BROWNOUT_TRIP_BIT = 10;
	localparam int STACK_RESET_BIT = 9;
	localparam int REG_CAP_N_BIT = 4;
	localparam int WRITE_PROTECT_LSB = 0;
	// part identity fields
	localparam int PART_CODE_W = 9;
	localparam int STEP_CODE_W = 5;

	// control and power control register bits
	localparam int CTRL_ERASE_BIT = 0;
	localparam int CTRL_RELOAD_BIT = 1;
	localparam int POWER_CONTROL_REGISTER_OVERFLOW_BIT = 0;
	localparam int POWER_CONTROL_REGISTER_UNDERFLOW_BIT = 1;

	// self-write protected ranges, last protected address
	localparam logic [14:0] WP_END_512 = 15'h01FF;
	localparam logic [14:0] WP_END_1K = 15'h03FF;
	localparam logic [14:0] WP_END_2K = 15'h07FF;
	localparam logic [14:0] WP_END_4K = 15'h0FFF;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		external_clock_high_power = 3'b111,
		external_clock_medium_power = 3'b110,
		external_clock_low_power = 3'b101,
		internal_oscillator = 3'b100,
		external_resistor_capacitor_mode = 3'b011,
		high_gain_crystal_mode = 3'b010,
		medium_gain_crystal_mode = 3'b001,
		low_power_crystal_mode = 3'b000
	} osc_mode_type;

	typedef enum logic [1:0] {
		mode_always_on = 2'b11,
		mode_run_only = 2'b10,
		mode_software = 2'b01,
		mode_off = 2'b00
	} enable_mode_type;

	typedef struct packed {
		logic [19:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [19:0] araddr;
		logic arvalid;
		logic rready;
	} axi_req_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} axi_rsp_type;

	typedef struct packed {
		logic clock_monitor_enable;
		logic two_speed_switchover_enable;
		logic clock_output_drive;
		logic clock_output_pin_gpio;
		osc_mode_type osc_mode;
		logic crystal_mode;
		logic brownout_run_enable;
		logic brownout_sleep_enable;
		logic watchdog_run_enable;
		logic watchdog_sleep_enable;
		logic code_protect_active;
		logic reset_pin_external;
		logic reset_pin_pullup_enable;
		logic powerup_delay_enable;
		logic low_voltage_programming_enable;
		logic debugger_pins_dedicated;
		logic low_power_brownout_enable;
		logic brownout_trip_low;
		logic stack_fault_reset_enable;
		logic regulator_capacitor_enable;
	} settings_type;

endpackage : config_pkg

// ==== config_checker_asserts.sv ====
// Purpose: concurrent checks on the configuration decoder's ports
// Assumes: one clock domain, srst synchronous active high
// Notes: bound to every instance of the decoder
`timescale 1ns/1ps
module config_checker (
	input wire logic clk,
	input wire logic srst,
	input wire config_pkg::axi_rsp_type axi_rsp,
	input wire logic stack_overflow_event,
	input wire logic stack_underflow_event,
	input wire logic stack_fault_reset,
	input wire logic ext_read_valid,
	input wire logic [13:0] ext_read_data_raw,
	input wire logic [13:0] ext_read_data,
	input wire logic ext_write_request,
	input wire logic ext_write_allowed,
	input wire logic external_reset_pin_high_voltage,
	input wire logic programming_entry_allowed,
	input wire config_pkg::settings_type settings
);
	import config_pkg::*;
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);
	// settings read all zero until two edges after reset release
	sequence settled;
		!$past(srst) && !$past(srst, 2);
	endsequence
	sequence stack_event;
		stack_overflow_event || stack_underflow_event;
	endsequence
	AST_EXT_WRITE_GATE: assert property (ext_write_allowed ==
		(ext_write_request && !settings.code_protect_active))
		else $error("external write gate wrong");
	AST_EXT_READ_ZERO: assert property (
		ext_read_valid && settings.code_protect_active |=>
		ext_read_data == 14'h0)
		else $error("protected read not zero");
	AST_EXT_READ_PASS: assert property (
		ext_read_valid && !settings.code_protect_active |=>
		ext_read_data == $past(ext_read_data_raw))
		else $error("open read data wrong");
	AST_STACK_FAULT: assert property (
		stack_event ##0 settings.stack_fault_reset_enable |=>
		stack_fault_reset)
		else $error("stack fault reset missing");
	AST_NO_FAULT: assert property (
		!((stack_overflow_event || stack_underflow_event) &&
		settings.stack_fault_reset_enable) |=> !stack_fault_reset)
		else $error("stack fault reset unexpected");
	AST_CLOCK_OUTPUT_PIN_CRYSTAL: assert property (settings.crystal_mode |->
		!settings.clock_output_drive && !settings.clock_output_pin_gpio)
		else $error("clock output used in crystal mode");
	AST_CRYSTAL_DECODE: assert property (settled |->
		settings.crystal_mode == (settings.osc_mode <= 3'b010))
		else $error("crystal mode decode wrong");
	AST_SETTINGS_STABLE: assert property (
		!$stable(settings) && !$past(srst, 2) && !$past(srst, 3) |->
		axi_rsp.bvalid || $past(axi_rsp.bvalid))
		else $error("settings changed without reload");
	AST_ENTRY_HV: assert property (
		external_reset_pin_high_voltage [*5] |-> programming_entry_allowed)
		else $error("high voltage entry refused");
	AST_ENTRY_NONE: assert property ((!external_reset_pin_high_voltage &&
		!settings.low_voltage_programming_enable) [*5] |->
		!programming_entry_allowed)
		else $error("entry without high voltage");
endmodule : config_checker

bind config_word_decode_and_protect config_checker config_checker_inst (
	.clk, .srst, .axi_rsp, .stack_overflow_event, .stack_underflow_event,
	.stack_fault_reset, .ext_read_valid, .ext_read_data_raw, .ext_read_data,
	.ext_write_request, .ext_write_allowed, .external_reset_pin_high_voltage,
	.programming_entry_allowed, .settings);

// ==== prog_model.sv ====
// Purpose: external programmer reading, writing and entering programming
// Assumes: every request changes just after a rising edge
// Notes: released read data shows the inverse of the last word
`timescale 1ns/1ps
module prog_model (
	input wire logic clk,
	output logic rd_valid,
	output logic [13:0] rd_raw,
	output logic wr_req,
	output logic hv,
	output logic lv
);
	// never asks for dedicated debugger pins
	initial {rd_valid, rd_raw, wr_req, hv, lv} = '0;
	task read_word(input logic [13:0] d);
		@(posedge clk);
		rd_valid <= 1'b1;
		rd_raw <= d;
		@(posedge clk);
		rd_valid <= 1'b0;
		rd_raw <= ~d;
	endtask : read_word
	task write_req(input logic r);
		@(posedge clk);
		wr_req <= r;
	endtask : write_req
	// high voltage is the only entry unless low-voltage entry is on
	task set_pins(input logic h, input logic l);
		@(posedge clk);
		hv <= h;
		lv <= l;
	endtask : set_pins
endmodule : prog_model

// ==== testbench.sv ====
// Purpose: register, protection and decode tests of the decoder
// Assumes: 40 MHz clock, AXI4-Lite master tasks, no random stimulus
// Notes: four configurations: protected, two mixed and erased
`timescale 1ns/1ps
module testbench;
	import config_pkg::*;
	localparam logic [8:0] PC = 9'h13A; // arbitrary
	localparam logic [4:0] SC = 5'h06; // arbitrary
	logic clk = 0, srst = 1, sb = 1, sw = 0, pu = 0, ovf = 0, unf = 0;
	logic swr = 0, swok, wok, fault, entry;
	logic [14:0] swa = 0;
	logic [13:0] xrd, xraw;
	logic xv, xw, hv, lv;
	axi_req_type rq = '0;
	axi_rsp_type rs;
	settings_type st;
	int num_errors = 0, total_checks = 0;
	always #12.5 clk = ~clk;
	config_word_decode_and_protect #(.PART_CODE(PC), .STEP_CODE(SC))
		config_word_decode_and_protect_inst (.clk(clk), .srst(srst),
		.axi_req(rq), .axi_rsp(rs), .software_brownout_enable(sb),
		.software_watchdog_enable(sw), .reset_pin_pullup_bit(pu),
		.stack_overflow_event(ovf), .stack_underflow_event(unf),
		.stack_fault_reset(fault), .ext_read_valid(xv),
		.ext_read_data_raw(xraw), .ext_read_data(xrd),
		.ext_write_request(xw), .ext_write_allowed(wok),
		.self_write_request(swr), .self_write_address(swa),
		.self_write_allowed(swok), .external_reset_pin_high_voltage(hv),
		.low_voltage_entry_pin(lv), .programming_entry_allowed(entry),
		.settings(st));
	prog_model prog_model_inst (.clk(clk), .rd_valid(xv), .rd_raw(xraw),
		.wr_req(xw), .hv(hv), .lv(lv));
	function automatic logic [19:0] ba(input logic [17:0] i);
		return {i, 2'b00};
	endfunction : ba
	function automatic settings_type ex(input logic [13:0] a, b);
		logic x;
		logic e;
		x = a[2:0] <= 3'b010;
		e = b[13] | a[6];
		return {a[13], a[12], ~x & ~a[11], ~x & a[11], a[2:0], x,
			a[10] | (a[10:9] == 2'b01 & sb), &a[10:9] | (a[10:9] == 2'b01 & sb),
			a[4] | (a[4:3] == 2'b01 & sw), &a[4:3] | (a[4:3] == 2'b01 & sw),
			~a[7], e, e | pu, ~a[5], b[13], ~b[12], ~b[11], b[10], b[9], ~b[4]};
	endfunction : ex
	task chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [19:0] a, input logic [31:0] d,
		input logic [1:0] r);
		@(posedge clk);
		rq.awaddr <= a;
		rq.wdata <= d;
		rq.wstrb <= 4'hF;
		rq.awvalid <= 1'b1;
		rq.wvalid <= 1'b1;
		rq.bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (rs.awready)
				rq.awvalid <= 1'b0;
			if (rs.wready)
				rq.wvalid <= 1'b0;
		end
		while (!rs.bvalid);
		rq.bready <= 1'b0;
		chk(rs.bresp, r);
	endtask : wr
	task automatic rd(input logic [19:0] a, input logic [31:0] e,
		input logic [1:0] r);
		@(posedge clk);
		rq.araddr <= a;
		rq.arvalid <= 1'b1;
		rq.rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (rs.arready)
				rq.arvalid <= 1'b0;
		end
		while (!rs.rvalid);
		rq.rready <= 1'b0;
		chk(rs.rdata, e);
		chk(rs.rresp, r);
	endtask : rd
	task automatic look(input logic [13:0] a, input logic [13:0] b);
		rd(ba(IDX_CFG_WORD1), {18'h0, a | 14'h0100}, RESP_OKAY);
		rd(ba(IDX_CFG_WORD2), {18'h0, b | 14'h01EC}, RESP_OKAY);
		wr(ba(IDX_CFG_WORD2), 32'h0, RESP_OKAY);
		rd(ba(IDX_SETTINGS), ex(a, b), RESP_OKAY);
		chk(st, ex(a, b));
		$display("config %h %h done", a, b);
	endtask : look
	task automatic load(input logic [13:0] a, input logic [13:0] b);
		wr(ba(IDX_NV_WORD1), {18'h0, a}, RESP_OKAY);
		wr(ba(IDX_NV_WORD2), {18'h0, b}, RESP_OKAY);
		wr(ba(IDX_CONTROL), 32'h2, RESP_OKAY);
		look(a, b);
	endtask : load
	task automatic xfer(input logic [13:0] d, e, input logic w);
		prog_model_inst.read_word(d);
		#1;
		chk(xrd, e);
		prog_model_inst.write_req(1'b1);
		#1;
		chk(wok, w);
		prog_model_inst.write_req(1'b0);
	endtask : xfer
	task automatic swchk(input logic [14:0] a, input logic e);
		@(posedge clk);
		swr <= 1'b1;
		swa <= a;
		#1;
		chk(swok, e);
		@(posedge clk);
		swr <= 1'b0;
	endtask : swchk
	task automatic stk(input logic o, u, f, input logic [31:0] e);
		@(posedge clk);
		ovf <= o;
		unf <= u;
		@(posedge clk);
		ovf <= 1'b0;
		unf <= 1'b0;
		#1;
		chk(fault, f);
		rd(ba(IDX_POWER_CONTROL), e, RESP_OKAY);
		wr(ba(IDX_POWER_CONTROL), 32'h3, RESP_OKAY);
		rd(ba(IDX_POWER_CONTROL), 32'h0, RESP_OKAY);
	endtask : stk
	task automatic pins(input logic h, l, e);
		prog_model_inst.set_pins(h, l);
		repeat (5) @(posedge clk);
		#1;
		chk(entry, e);
	endtask : pins
	task results;
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results
	initial
	begin
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		look(14'h3FFF, 14'h3FFF);
		wr(ba(IDX_PART_IDENTITY), 32'h0, RESP_OKAY);
		rd(ba(IDX_PART_IDENTITY), {18'h0, PC, SC}, RESP_OKAY);
		for (int i = 0; i < 4; i++)
			wr(ba(IDX_USER_ID0 + 18'(i)), 32'h0000_2A50 + i, RESP_OKAY);
		for (int i = 0; i < 4; i++)
			rd(ba(IDX_USER_ID0 + 18'(i)), 32'h0000_2A50 + i, RESP_OKAY);
		rd(20'h2_0060, 32'h0, RESP_SLVERR);
		wr(20'h2_0060, 32'h1, RESP_SLVERR);
		$display("registers done");
		load(14'h0000, 14'h0000);
		xfer(14'h1555, 14'h0000, 1'b0);
		swchk(15'h07FF, 1'b0);
		swchk(15'h0800, 1'b1);
		stk(1'b1, 1'b0, 1'b0, 32'h1);
		load(14'h23B4, 14'h0602);
		xfer(14'h2AAA, 14'h2AAA, 1'b1);
		swchk(15'h01FF, 1'b0);
		swchk(15'h0200, 1'b1);
		stk(1'b0, 1'b1, 1'b1, 32'h2);
		pins(1'b0, 1'b1, 1'b0);
		pins(1'b1, 1'b0, 1'b1);
		load(14'h148F, 14'h3811);
		swchk(15'h03FF, 1'b0);
		swchk(15'h0400, 1'b1);
		wr(ba(IDX_CONTROL), 32'h3, RESP_OKAY);
		look(14'h3FFF, 14'h3FFF);
		rd(ba(IDX_NV_WORD1), 32'h0000_3FFF, RESP_OKAY);
		rd(ba(IDX_USER_ID0), 32'h0000_3FFF, RESP_OKAY);
		swchk(15'h07FF, 1'b1);
		pins(1'b0, 1'b1, 1'b1);
		$display("protection done");
		results();
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		results();
	end
endmodule : testbench
